// >>> include/mhf_pkg.sv
// Package of constants for the multicast hash filter block
package mhf_pkg;
   localparam int          ADDR_LEN_DEF    = 6;
   localparam int          CNT_W           = 14;
   localparam int          HASH_BITS       = 64;
   localparam int          HASH_IDX_W      = 6;
   localparam int          CRC_W           = 32;
   localparam int          HASH_LSB        = 2;
   localparam int          HASH_MSB        = 7;
   localparam logic [31:0] CRC_POLY        = 32'h04c11db7;
   localparam logic [31:0] CRC_INIT        = 32'hffffffff;
   localparam logic [2:0]  OP_MC_LOAD      = 3'h3;
   localparam int          CMD_OP_LSB      = 0;
   localparam int          CMD_OP_MSB      = 2;
   localparam int          CMD_INT_BIT     = 13;
   localparam int          CMD_HOLD_BIT    = 14;
   localparam int          CMD_LAST_BIT    = 15;
   localparam int          ST_ABORT_BIT    = 12;
   localparam int          ST_OK_BIT       = 13;
   localparam int          ST_BUSY_BIT     = 14;
   localparam int          ST_DONE_BIT     = 15;
   localparam logic [15:0] STATUS_RESET    = 16'h0000;
   localparam logic [15:0] STATUS_BUSY     = 16'h4000;
   localparam logic [15:0] STATUS_DONE_OK  = 16'ha000;
   localparam logic [15:0] STATUS_ABORTED  = 16'h9000;
endpackage

// >>> logic/mhf_crc_byte.sv
// One byte step of the address CRC, least significant bit first
`timescale 1ns/1ps
module mhf_crc_byte
   import mhf_pkg::*;
(
   // Inputs
   input  wire logic [31:0] crc_in,
   input  wire logic [7:0]  data_in,
   // Result
   output logic      [31:0] crc_out
);
   always_comb begin
      logic [31:0] c;
      c = crc_in;
      for (int i = 0; i < 8; i++) begin
         if (c[31] ^ data_in[i]) begin
            c = {c[30:0], 1'b0} ^ CRC_POLY;
         end else begin
            c = {c[30:0], 1'b0};
         end
      end
      crc_out = c;
   end
endmodule

// >>> logic/mhf_hash_lookup.sv
// Receive side lookup of a destination address in the hash table
`timescale 1ns/1ps
module mhf_hash_lookup
   import mhf_pkg::*;
#(
   parameter int ADDR_LEN = ADDR_LEN_DEF
)
(
   // Address and table
   input  wire logic [8*ADDR_LEN-1:0] addr,
   input  wire logic [HASH_BITS-1:0]  table_bits,
   // Result
   output logic                       hit
);
   logic [31:0] crc_chain [0:ADDR_LEN];
   logic [HASH_IDX_W-1:0] idx;
   assign crc_chain[0] = CRC_INIT;
   genvar g;
   generate
      for (g = 0; g < ADDR_LEN; g++) begin : g_byte
         mhf_crc_byte u_step (
            .crc_in  (crc_chain[g]),
            .data_in (addr[8*g +: 8]),
            .crc_out (crc_chain[g+1])
         );
      end
   endgenerate
   assign idx = crc_chain[ADDR_LEN][HASH_MSB:HASH_LSB];
   assign hit = addr[0] & table_bits[idx];
endmodule

// >>> logic/mhf_filter.sv
// Multicast load command engine and receive hash filter
`timescale 1ns/1ps
// Functional notes
// - After a load, frames to loaded multicast addresses are accepted.
// - Status word: done bit 15, busy 14, ok 13, aborted 12.
// - Command word: last 15, hold 14, interrupt 13, op code 3 in bits 0-2.
// - List byte count is a 14-bit field.
// - Count is truncated to a multiple of the address length.
// - Zero count makes every multicast frame rejected afterwards.
// - A 64-bit hash table is kept for receive multicast checks.
// - Accept only when address bit 0 is one and table bit is one.
// - Hash index is CRC register bits 2 through 7.
// - Reset clears every hash table bit.
// - On a load, clear the table first, then read grouped bytes.
// - Each full group is hashed and its indexed bit set.
// - A short trailing group leaves the table unchanged.
// - After all groups, completion is signalled to the command unit.
module mhf_filter
   import mhf_pkg::*;
#(
   parameter int ADDR_LEN = ADDR_LEN_DEF
)
(
   // Clock and reset
   input  wire logic                  clk_sys,
   input  wire logic                  reset,
   // Command fetch
   input  wire logic                  cmd_valid,
   input  wire logic [15:0]           cmd_word,
   input  wire logic [CNT_W-1:0]      list_byte_count,
   // Group address list bytes
   input  wire logic                  list_valid,
   input  wire logic [7:0]            list_byte,
   // Receive destination check
   input  wire logic                  rx_da_valid,
   input  wire logic [8*ADDR_LEN-1:0] rx_da,
   // Command handshakes
   output logic                       cmd_ready,
   output logic                       list_ready,
   output logic                       command_unit_done,
   output logic [15:0]                status_word,
   output logic                       status_write,
   // Receive decision
   output logic                       rx_accept_valid,
   output logic                       rx_accept,
   // Table view
   output logic [HASH_BITS-1:0]       hash_table
);
   if (ADDR_LEN < 1 || ADDR_LEN > 8) begin : g_bad_len
      $error("ADDR_LEN out of range");
   end

   typedef enum logic [1:0] {
      ST_IDLE  = 2'b00,
      ST_CLEAR = 2'b01,
      ST_LOAD  = 2'b10,
      ST_DONE  = 2'b11
   } mhf_state_t;

   localparam logic [CNT_W-1:0] ALEN = CNT_W'(ADDR_LEN);
   localparam logic [3:0]       LAST_POS = 4'(ADDR_LEN - 1);

   mhf_state_t              state_reg;
   logic [CNT_W-1:0]        bytes_left_reg;
   logic [3:0]              pos_reg;
   logic [31:0]             crc_reg;
   logic [31:0]             crc_next;
   logic [HASH_BITS-1:0]    table_reg;
   logic [HASH_IDX_W-1:0]   set_idx;
   logic                    is_load;
   logic                    lookup_hit;
   logic [CNT_W-1:0]        trunc_cnt;

   // Truncate count to whole groups
   assign trunc_cnt = list_byte_count - (list_byte_count % ALEN);
   assign is_load   = cmd_word[CMD_OP_MSB:CMD_OP_LSB] == OP_MC_LOAD;
   assign hash_table = table_reg;

   mhf_crc_byte u_crc (
      .crc_in  ((pos_reg == 4'h0) ? CRC_INIT : crc_reg),
      .data_in (list_byte),
      .crc_out (crc_next)
   );
   assign set_idx = crc_next[HASH_MSB:HASH_LSB];

   mhf_hash_lookup #(.ADDR_LEN(ADDR_LEN)) u_lookup (
      .addr       (rx_da),
      .table_bits (table_reg),
      .hit        (lookup_hit)
   );

   // Command sequencer
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         state_reg      <= ST_IDLE;
         bytes_left_reg <= '0;
      end else begin
         unique case (state_reg)
            ST_IDLE: begin
               if (cmd_valid && is_load) begin
                  state_reg      <= ST_CLEAR;
                  bytes_left_reg <= trunc_cnt;
               end
            end
            ST_CLEAR: begin
               state_reg <= (bytes_left_reg == '0) ? ST_DONE : ST_LOAD;
            end
            ST_LOAD: begin
               if (list_valid) begin
                  bytes_left_reg <= bytes_left_reg - 1'b1;
                  if (bytes_left_reg == 14'h0001) begin
                     state_reg <= ST_DONE;
                  end
               end
            end
            ST_DONE: begin
               state_reg <= ST_IDLE;
            end
         endcase
      end
   end

   AST_TAKE: assert property (@(posedge clk_sys) disable iff (reset)
      state_reg == ST_IDLE && cmd_valid && is_load |=> state_reg == ST_CLEAR)
      else $error("load command not taken");

   AST_ZERO_DONE: assert property (@(posedge clk_sys) disable iff (reset)
      state_reg == ST_CLEAR && bytes_left_reg == '0 |=> state_reg == ST_DONE)
      else $error("zero count did not finish");

   AST_LOAD_NEXT: assert property (@(posedge clk_sys) disable iff (reset)
      state_reg == ST_CLEAR && bytes_left_reg != '0 |=> state_reg == ST_LOAD)
      else $error("list read not started");

   AST_IGNORE_OP: assert property (@(posedge clk_sys) disable iff (reset)
      state_reg == ST_IDLE && cmd_valid && !is_load |=> state_reg == ST_IDLE)
      else $error("other op code taken");

   AST_BYTES_DOWN: assert property (@(posedge clk_sys) disable iff (reset)
      state_reg == ST_LOAD && list_valid
      |=> bytes_left_reg == $past(bytes_left_reg) - 14'h0001)
      else $error("byte count not stepped");

   AST_DONE_IDLE: assert property (@(posedge clk_sys) disable iff (reset)
      state_reg == ST_DONE |=> state_reg == ST_IDLE)
      else $error("done state not left");

   // Byte position within group and running CRC
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         pos_reg <= 4'h0;
         crc_reg <= CRC_INIT;
      end else if (state_reg == ST_CLEAR) begin
         pos_reg <= 4'h0;
         crc_reg <= CRC_INIT;
      end else if (state_reg == ST_LOAD && list_valid) begin
         crc_reg <= crc_next;
         pos_reg <= (pos_reg == LAST_POS) ? 4'h0 : pos_reg + 4'h1;
      end
   end

   AST_CRC_RESTART: assert property (@(posedge clk_sys) disable iff (reset)
      state_reg == ST_CLEAR |=> crc_reg == CRC_INIT && pos_reg == 4'h0)
      else $error("crc not restarted");

   AST_POS_WRAP: assert property (@(posedge clk_sys) disable iff (reset)
      state_reg == ST_LOAD && list_valid && pos_reg == LAST_POS |=> pos_reg == 4'h0)
      else $error("group position not restarted");

   AST_CRC_HOLD: assert property (@(posedge clk_sys) disable iff (reset)
      state_reg == ST_LOAD && !list_valid
      |=> crc_reg == $past(crc_reg) && pos_reg == $past(pos_reg))
      else $error("group state moved without a byte");

   // Hash table
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         table_reg <= '0;
      end else if (state_reg == ST_CLEAR) begin
         table_reg <= '0;
      end else if (state_reg == ST_LOAD && list_valid && pos_reg == LAST_POS) begin
         table_reg[set_idx] <= 1'b1;
      end
   end

   AST_RESET_TABLE: assert property (@(posedge clk_sys)
      reset |=> table_reg == '0)
      else $error("reset left table bits");

   AST_TABLE_KEPT: assert property (@(posedge clk_sys) disable iff (reset)
      state_reg == ST_IDLE |=> table_reg == $past(table_reg))
      else $error("table changed while idle");

   AST_ONE_BIT: assert property (@(posedge clk_sys) disable iff (reset)
      state_reg == ST_LOAD && list_valid && pos_reg == LAST_POS
      |=> $countones(table_reg ^ $past(table_reg)) <= 1)
      else $error("more than one table bit changed");

   AST_NO_CLEAR_LOAD: assert property (@(posedge clk_sys) disable iff (reset)
      state_reg == ST_LOAD |=> (table_reg & $past(table_reg)) == $past(table_reg))
      else $error("table bit lost during load");

   // Handshakes and status
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         cmd_ready         <= 1'b0;
         list_ready        <= 1'b0;
         command_unit_done <= 1'b0;
         status_word       <= STATUS_RESET;
         status_write      <= 1'b0;
      end else begin
         cmd_ready         <= (state_reg == ST_IDLE) && !(cmd_valid && is_load);
         list_ready        <= (state_reg == ST_CLEAR && bytes_left_reg != '0) ||
                              (state_reg == ST_LOAD &&
                               !(list_valid && bytes_left_reg == 14'h0001));
         command_unit_done <= (state_reg == ST_DONE);
         status_write      <= 1'b0;
         if (state_reg == ST_IDLE && cmd_valid && is_load) begin
            status_word  <= STATUS_BUSY;
            status_write <= 1'b1;
         end else if (state_reg == ST_DONE) begin
            status_word  <= STATUS_DONE_OK;
            status_write <= 1'b1;
         end
      end
   end

   AST_READY_IDLE: assert property (@(posedge clk_sys) disable iff (reset)
      cmd_ready |-> state_reg == ST_IDLE)
      else $error("ready while busy");

   AST_LIST_LOAD: assert property (@(posedge clk_sys) disable iff (reset)
      list_ready |-> state_reg == ST_LOAD)
      else $error("list request outside load");

   AST_LIST_LAST: assert property (@(posedge clk_sys) disable iff (reset)
      state_reg == ST_LOAD && list_valid && bytes_left_reg == 14'h0001 |=> !list_ready)
      else $error("bytes requested past count");

   AST_DONE_PULSE: assert property (@(posedge clk_sys) disable iff (reset)
      command_unit_done |=> !command_unit_done)
      else $error("completion longer than one cycle");

   AST_STATUS_WR: assert property (@(posedge clk_sys) disable iff (reset)
      state_reg == ST_DONE |=> status_write)
      else $error("completion status not written");

   AST_BUSY_WRITE: assert property (@(posedge clk_sys) disable iff (reset)
      state_reg == ST_IDLE && cmd_valid && is_load |=> status_write && status_word == STATUS_BUSY)
      else $error("busy status not written");

   AST_NO_ABORT: assert property (@(posedge clk_sys) disable iff (reset)
      status_write |-> !status_word[ST_ABORT_BIT])
      else $error("aborted flag written");

   AST_RESET_STATUS: assert property (@(posedge clk_sys)
      reset |=> status_word == STATUS_RESET && !status_write && !command_unit_done)
      else $error("status not reset");

   // Receive decision
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         rx_accept_valid <= 1'b0;
         rx_accept       <= 1'b0;
      end else begin
         rx_accept_valid <= rx_da_valid;
         rx_accept       <= rx_da_valid && lookup_hit;
      end
   end

   AST_RX_VALID: assert property (@(posedge clk_sys) disable iff (reset)
      rx_da_valid |=> rx_accept_valid)
      else $error("no decision for address");

   AST_RX_IDLE: assert property (@(posedge clk_sys) disable iff (reset)
      !rx_da_valid |=> !rx_accept_valid)
      else $error("decision without address");

   AST_RX_UNI: assert property (@(posedge clk_sys) disable iff (reset)
      rx_da_valid && !rx_da[0] |=> !rx_accept)
      else $error("individual address accepted");

   AST_RX_QUAL: assert property (@(posedge clk_sys) disable iff (reset)
      rx_accept |-> rx_accept_valid)
      else $error("accept without valid");

   AST_CLEAR_FIRST: assert property (@(posedge clk_sys) disable iff (reset)
      state_reg == ST_CLEAR |=> table_reg == '0)
      else $error("table not cleared");

   AST_DONE_AFTER: assert property (@(posedge clk_sys) disable iff (reset)
      state_reg == ST_DONE |=> command_unit_done && status_word == STATUS_DONE_OK)
      else $error("completion missing");

   AST_BUSY: assert property (@(posedge clk_sys) disable iff (reset)
      state_reg == ST_IDLE && cmd_valid && is_load |=> status_word[ST_BUSY_BIT])
      else $error("busy not set");

   AST_OK_BITS: assert property (@(posedge clk_sys) disable iff (reset)
      command_unit_done |-> status_word[ST_DONE_BIT] && status_word[ST_OK_BIT]
      && !status_word[ST_BUSY_BIT] && !status_word[ST_ABORT_BIT])
      else $error("status bits wrong");

   AST_ZERO_CNT: assert property (@(posedge clk_sys) disable iff (reset)
      state_reg == ST_CLEAR && bytes_left_reg == '0 |=> ##1 table_reg == '0)
      else $error("zero count left bits");

   AST_ACCEPT_LSB: assert property (@(posedge clk_sys) disable iff (reset)
      rx_accept |-> $past(rx_da[0]))
      else $error("accepted unicast");

   AST_SHORT_GROUP: assert property (@(posedge clk_sys) disable iff (reset)
      state_reg == ST_LOAD && pos_reg != LAST_POS |=> table_reg == $past(table_reg))
      else $error("partial group touched table");

   AST_SET_BIT: assert property (@(posedge clk_sys) disable iff (reset)
      state_reg == ST_LOAD && list_valid && pos_reg == LAST_POS
      |=> table_reg[$past(set_idx)])
      else $error("hash bit not set");

   AST_TRUNC: assert property (@(posedge clk_sys) disable iff (reset)
      state_reg == ST_CLEAR |-> bytes_left_reg % ALEN == '0)
      else $error("count not truncated");
endmodule

// >>> sim/mhf_host.sv
// Host model issuing multicast load commands and list bytes
`timescale 1ns/1ps
module mhf_host
   import mhf_pkg::*;
(
   // Clock and device answers
   input  wire logic        clk_sys,
   input  wire logic        cmd_ready,
   input  wire logic        list_ready,
   input  wire logic        done,
   // Command and list
   output logic             cmd_valid,
   output logic [15:0]      cmd_word,
   output logic [CNT_W-1:0] list_byte_count,
   output logic             list_valid,
   output logic [7:0]       list_byte
);
   logic [7:0] mem [0:63];
   initial begin
      cmd_valid = 1'b0;
      cmd_word = 16'h0000;
      list_byte_count = '0;
      list_valid = 1'b0;
      list_byte = 8'h00;
   end
   // Command driven for one cycle once cmd_ready is seen, then bytes fed only while asked for
   task automatic run(input logic [2:0] op, input int n);
      int idx;
      idx = 0;
      @(posedge clk_sys);
      #1;
      while (cmd_ready !== 1'b1) begin
         @(posedge clk_sys);
         #1;
      end
      cmd_word = {3'h7, 10'h000, op};
      list_byte_count = n[CNT_W-1:0];
      cmd_valid = 1'b1;
      @(posedge clk_sys);
      #1;
      cmd_valid = 1'b0;
      for (int g = 0; g < 300 && done !== 1'b1; g++) begin
         if (list_ready === 1'b1 && idx < n && $urandom_range(3) != 0) begin
            list_valid = 1'b1;
            list_byte = mem[idx];
            idx++;
         end else begin
            list_valid = 1'b0;
            list_byte = ~list_byte;
         end
         @(posedge clk_sys);
         #1;
      end
      list_valid = 1'b0;
   endtask
endmodule

// >>> sim/tb.sv
// Self-checking bench of the multicast hash filter
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin err_count++; \
   $display("[FAIL] %s exp %0h got %0h", nm, e, g); end end
module tb
   import mhf_pkg::*;
;
   localparam int AL = 6;
   logic             clk_sys, reset, cmd_valid, list_valid, rx_da_valid;
   logic             cmd_ready, list_ready, command_unit_done, status_write;
   logic             rx_accept_valid, rx_accept;
   logic [15:0]      cmd_word, status_word;
   logic [CNT_W-1:0] list_byte_count;
   logic [7:0]       list_byte;
   logic [8*AL-1:0]  rx_da, da;
   logic [63:0]      exp_tab;
   logic [47:0]      addrs [0:7];
   logic [15:0]      st_q [$];
   int               err_count = 0;
   int               n_compared = 0;
   int               cycles = 0;
   int               done_cnt = 0;
   int               lens [5] = '{5*AL+3, 8*AL, AL-1, 0, AL};
   mhf_filter #(.ADDR_LEN(AL)) u_dut (.clk_sys(clk_sys), .reset(reset),
      .cmd_valid(cmd_valid), .cmd_word(cmd_word), .list_byte_count(list_byte_count),
      .list_valid(list_valid), .list_byte(list_byte), .rx_da_valid(rx_da_valid),
      .rx_da(rx_da), .cmd_ready(cmd_ready), .list_ready(list_ready),
      .command_unit_done(command_unit_done), .status_word(status_word),
      .status_write(status_write), .rx_accept_valid(rx_accept_valid),
      .rx_accept(rx_accept), .hash_table());
   mhf_host u_host (.clk_sys(clk_sys), .cmd_ready(cmd_ready), .list_ready(list_ready),
      .done(command_unit_done), .cmd_valid(cmd_valid), .cmd_word(cmd_word),
      .list_byte_count(list_byte_count), .list_valid(list_valid), .list_byte(list_byte));
   // Table index of one address, bit 0 of byte 0 first
   function automatic logic [5:0] hidx(input logic [47:0] a);
      logic [31:0] c;
      c = CRC_INIT;
      for (int i = 0; i < 48; i++) begin
         c = {c[30:0], 1'b0} ^ ((c[31] ^ a[i]) ? CRC_POLY : 32'h0);
      end
      return c[HASH_MSB:HASH_LSB];
   endfunction
   task automatic final_report();
      $display("compared %0d mismatches %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   initial begin
      clk_sys = 1'b0;
      forever #2 clk_sys = ~clk_sys;
   end
   always @(posedge clk_sys) begin
      cycles <= cycles + 1;
      if (status_write === 1'b1)
         st_q.push_back(status_word);
      if (command_unit_done === 1'b1)
         done_cnt++;
      if (cycles == 20000) begin
         err_count++;
         final_report();
      end
   end
   // One load of n list bytes with fresh random addresses
   task automatic load(input int n);
      st_q.delete();
      done_cnt = 0;
      exp_tab = '0;
      for (int k = 0; k < 8; k++) begin
         addrs[k] = 48'({$urandom, $urandom}) | 48'h1;
         for (int j = 0; j < AL; j++)
            u_host.mem[k*AL+j] = addrs[k][8*j+:8];
         if (k < n / AL)
            exp_tab[hidx(addrs[k])] = 1'b1;
      end
      u_host.run(OP_MC_LOAD, n);
      @(posedge clk_sys);
      #1;
      `CHK("status writes", 2, st_q.size())
      `CHK("busy status", STATUS_BUSY, st_q[0])
      `CHK("done status", STATUS_DONE_OK, st_q[1])
      `CHK("table", exp_tab, u_dut.hash_table)
      `CHK("done pulses", 1, done_cnt)
      `CHK("ready after load", 1'b1, cmd_ready)
      `CHK("list request off", 1'b0, list_ready)
   endtask
   task automatic rx(input logic [47:0] a, input logic want);
      @(posedge clk_sys);
      #1;
      rx_da = a;
      rx_da_valid = 1'b1;
      @(posedge clk_sys);
      #1;
      rx_da_valid = 1'b0;
      rx_da = ~a;
      for (int w = 0; w < 3 && rx_accept_valid !== 1'b1; w++) begin
         @(posedge clk_sys);
         #1;
      end
      `CHK("accept valid", 1'b1, rx_accept_valid)
      `CHK("accept", want, rx_accept)
   endtask
   initial begin
      void'($urandom(32'h55eb));
      reset = 1'b1;
      rx_da_valid = 1'b0;
      rx_da = '0;
      repeat (6) @(posedge clk_sys);
      #1;
      reset = 1'b0;
      `CHK("reset table", 64'h0, u_dut.hash_table)
      `CHK("reset status", STATUS_RESET, status_word)
      foreach (lens[i]) begin
         load(lens[i]);
         for (int k = 0; k < 4; k++)
            rx(addrs[k], exp_tab[hidx(addrs[k])]);
         rx(addrs[0] & ~48'h1, 1'b0);
         da = 48'({$urandom, $urandom});
         rx(da, da[0] & exp_tab[hidx(da)]);
      end
      st_q.delete();
      u_host.run(3'h4, 0);
      `CHK("refused op", 0, st_q.size())
      `CHK("table kept", exp_tab, u_dut.hash_table)
      reset = 1'b1;
      repeat (2) @(posedge clk_sys);
      #1;
      reset = 1'b0;
      `CHK("table after reset", 64'h0, u_dut.hash_table)
      `CHK("ready in reset", 1'b0, cmd_ready)
      load(2*AL);
      rx(addrs[1], exp_tab[hidx(addrs[1])]);
      final_report();
   end
endmodule
